// >>> verification/sbc_bus_model.sv
// Behavioural two-wire bus master on open-drain clock and data lines.
// Assumes pull-ups: a released line reads high; link clock period 80 ns.
`timescale 1ns/1ps
module sbc_bus_model (
    // Resolved lines
    input  wire logic scl_w,
    input  wire logic sda_w,
    // Drives, 0 pulls low
    output logic      scl_drv,
    output logic      sda_drv
);
    initial begin
        scl_drv = 1'b1;
        sda_drv = 1'b1;
    end
    // Each task starts 1 ns off the system clock edge to keep pin changes off it
    task automatic start_cond;
        #1;
        sda_drv = 1'b0;
        #40 scl_drv = 1'b0;
        #40;
    endtask : start_cond
    task automatic stop_cond;
        #1;
        #20 sda_drv = 1'b0;
        #20 scl_drv = 1'b1;
        #40 sda_drv = 1'b1;
        #40;
    endtask : stop_cond
    task automatic send_byte(input logic [7:0] d, input logic ack);
        logic [8:0] b;
        b = {d, ack};
        #1;
        for (int i = 8; i >= 0; i--) begin
            #20 sda_drv = b[i];
            #20 scl_drv = 1'b1;
            // Device may hold the clock low
            wait (scl_w === 1'b1);
            #40 scl_drv = 1'b0;
        end
        #20 sda_drv = 1'b1;
        #40;
    endtask : send_byte
endmodule : sbc_bus_model

// >>> verification/sbc_status_clksel_monitor.sv
// Checker for the APB side and line drivers of the two-wire block.
// Assumes it is bound to sbc_status_clksel and sees its ports only.
`timescale 1ns/1ps
module sbc_status_clksel_monitor
    import sbc_pkg::*;
#(
    parameter int FILT_CYC = sbc_pkg::FILT_CYC
) (
    // Clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // APB
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Lines
    input wire logic        serial_clock_line_in,
    input wire logic        serial_clock_line_out,
    input wire logic        serial_clock_line_oe_n,
    input wire logic        serial_data_line_in,
    input wire logic        serial_data_line_out,
    input wire logic        serial_data_line_oe_n,
    // Interrupt
    input wire logic        irq
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire        done = psel && penable && pready;
    wire [15:0] idx  = paddr[17:2];
    wire        ok   = paddr[31:18] == 14'h0 && paddr[1:0] == 2'b00;
    wire        ctl  = done && pwrite && ok && idx == IDX_CONTROL;
    wire        rdd  = done && !pwrite && ok;
    wire        map  = ok && (idx inside {IDX_STATUS, IDX_CLKSEL, IDX_CONTROL,
                                          IDX_IRQ_STAT, IDX_IRQ_MASK});
    wire        free = serial_clock_line_oe_n && serial_data_line_oe_n;

    property p_ready_pulse; pready |=> !pready; endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("pready too long");
    property p_ready_late; psel && penable && !$past(penable) |=> pready; endproperty
    a_ready_late: assert property (p_ready_late) else $error("pready late");
    property p_err; done |-> pslverr == !map; endproperty
    a_err: assert property (p_err) else $error("pslverr wrong");
    property p_rd_hi; pready |-> prdata[31:8] == 24'h0; endproperty
    a_rd_hi: assert property (p_rd_hi) else $error("prdata high bits");
    property p_stat_hi; rdd && idx == IDX_STATUS |-> prdata[7:4] == 4'h0; endproperty
    a_stat_hi: assert property (p_stat_hi) else $error("status high bits");
    property p_cs_top; rdd && idx == IDX_CLKSEL |-> prdata[7:6] == 2'b00; endproperty
    a_cs_top: assert property (p_cs_top) else $error("clock select top bits");
    property p_wrel;
        ctl && pwdata[CTL_WAIT_REL] && pwdata[CTL_ENABLE] && !pwdata[CTL_TX_SET]
            && !serial_clock_line_oe_n |-> ##[1:3] free;
    endproperty
    a_wrel: assert property (p_wrel) else $error("wait not released");
    property p_rel;
        ctl && pwdata[CTL_RELEASE] && !pwdata[CTL_TX_SET] |-> ##[1:3] free;
    endproperty
    a_rel: assert property (p_rel) else $error("release ignored");
    property p_off; ctl && !pwdata[CTL_ENABLE] |-> ##[1:3] free [*3]; endproperty
    a_off: assert property (p_off) else $error("drivers on when disabled");
    property p_sync; $fell(serial_clock_line_oe_n) |-> !$past(serial_clock_line_in, 2);
    endproperty
    a_sync: assert property (p_sync) else $error("wait before synced fall");
    property p_od; !serial_clock_line_out && !serial_data_line_out; endproperty
    a_od: assert property (p_od) else $error("open drain data not 0");
endmodule : sbc_status_clksel_monitor

bind sbc_status_clksel sbc_status_clksel_monitor #(.FILT_CYC(FILT_CYC)) u_mon (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .serial_clock_line_in, .serial_clock_line_out, .serial_clock_line_oe_n,
    .serial_data_line_in, .serial_data_line_out, .serial_data_line_oe_n, .irq);

// >>> verification/sbc_status_clksel_tb_top.sv
// Self-checking bench: register access over APB and frames from a bus model.
// Assumes the design package; both serial lines have pull-ups.
`timescale 1ns/1ps
module sbc_status_clksel_tb_top;
    import sbc_pkg::*;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [31:0] paddr = 32'h0;
    logic [31:0] pwdata = 32'h0;
    wire  [31:0] prdata;
    wire         pready, pslverr, irq, scl_oe_n, sda_oe_n, scl_drv, sda_drv;
    wire         scl_w = scl_oe_n & scl_drv;
    wire         sda_w = sda_oe_n & sda_drv;
    int          miscompares = 0;
    int          total_checks = 0;
    logic [7:0]  rd;
    logic        er;

    always #4 pclk = ~pclk;

    sbc_status_clksel #(.FILT_CYC(2)) u_sbc_status_clksel (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .serial_clock_line_in(scl_w), .serial_clock_line_out(),
        .serial_clock_line_oe_n(scl_oe_n), .serial_data_line_in(sda_w),
        .serial_data_line_out(), .serial_data_line_oe_n(sda_oe_n), .irq);
    sbc_bus_model u_sbc_bus_model (.scl_w, .sda_w, .scl_drv, .sda_drv);

    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        total_checks++;
        if (g !== e) begin
            miscompares++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    task automatic apb(input logic [15:0] i, input logic w, input logic [7:0] d);
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= {14'h0, i, 2'b00};
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata[7:0];
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rdc(input logic [15:0] i, input logic [7:0] e);
        apb(i, 1'b0, 8'h00);
        chk(rd, e);
    endtask : rdc
    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask : cyc

    task automatic t_reset_values;
        rdc(IDX_STATUS, RST_STATUS);
        rdc(IDX_CLKSEL, RST_CLKSEL);
        chk({7'h0, irq}, 8'h00);
    endtask : t_reset_values
    task automatic t_clock_select;
        apb(IDX_CLKSEL, 1'b1, 8'hFF);
        rdc(IDX_CLKSEL, 8'h0F);
        apb(IDX_STATUS, 1'b1, 8'hFF);
        rdc(IDX_STATUS, 8'h00);
        apb(16'hFF7B, 1'b0, 8'h00);
        chk({7'h0, er}, 8'h01);
        apb(IDX_CLKSEL, 1'b1, 8'h00);
        rdc(IDX_CLKSEL, 8'h00);
        apb(IDX_CONTROL, 1'b1, 8'h80);
        cyc(8);
        rdc(IDX_CLKSEL, 8'h30);
    endtask : t_clock_select
    task automatic t_frame_flags;
        u_sbc_bus_model.start_cond();
        u_sbc_bus_model.stop_cond();
        rdc(IDX_STATUS, 8'h01);
        chk({7'h0, irq}, 8'h00);
        apb(IDX_IRQ_MASK, 1'b1, 8'h01);
        cyc(2);
        chk({7'h0, irq}, 8'h01);
        apb(IDX_IRQ_STAT, 1'b1, 8'h07);
        cyc(2);
        chk({7'h0, irq}, 8'h00);
        u_sbc_bus_model.start_cond();
        rdc(IDX_STATUS, 8'h03);
        u_sbc_bus_model.send_byte(8'hA4, 1'b0);
        rdc(IDX_STATUS, 8'h06);
        rdc(IDX_CLKSEL, 8'h10);
        apb(IDX_CONTROL, 1'b1, 8'h88);
        cyc(2);
        rdc(IDX_STATUS, 8'h0E);
        chk({7'h0, sda_oe_n}, 8'h00);
        apb(IDX_CONTROL, 1'b1, 8'hA0);
        cyc(2);
        rdc(IDX_STATUS, 8'h06);
        chk({6'h0, scl_oe_n, sda_oe_n}, 8'h03);
        rdc(IDX_CONTROL, 8'h80);
        u_sbc_bus_model.send_byte(8'h5B, 1'b1);
        rdc(IDX_STATUS, 8'h00);
        rdc(IDX_IRQ_STAT, 8'h06);
    endtask : t_frame_flags
    task automatic t_release_disable;
        apb(IDX_CONTROL, 1'b1, 8'hA0);
        u_sbc_bus_model.send_byte(8'hC3, 1'b0);
        rdc(IDX_STATUS, 8'h04);
        apb(IDX_CONTROL, 1'b1, 8'hC0);
        rdc(IDX_STATUS, 8'h00);
        u_sbc_bus_model.stop_cond();
        apb(IDX_CONTROL, 1'b1, 8'hC0);
        rdc(IDX_STATUS, 8'h01);
        apb(IDX_CONTROL, 1'b1, 8'h00);
        rdc(IDX_STATUS, 8'h00);
        rdc(IDX_CLKSEL, 8'h00);
    endtask : t_release_disable
    task automatic t_filter_mode;
        apb(IDX_CLKSEL, 1'b1, 8'h0C);
        apb(IDX_CONTROL, 1'b1, 8'h80);
        cyc(8);
        rdc(IDX_CLKSEL, 8'h3C);
        u_sbc_bus_model.start_cond();
        rdc(IDX_STATUS, 8'h02);
        u_sbc_bus_model.stop_cond();
        rdc(IDX_STATUS, 8'h01);
    endtask : t_filter_mode

    task automatic tally_and_finish;
        if (miscompares == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : tally_and_finish

    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        t_reset_values();
        t_clock_select();
        t_frame_flags();
        t_release_disable();
        t_filter_mode();
        tally_and_finish();
    end
    initial begin
        #100000;
        miscompares++;
        tally_and_finish();
    end
endmodule : sbc_status_clksel_tb_top

// >>> verilog/sbc_line_filter.sv
// Two-flop synchroniser with an optional stability filter for one bus line.
// Assumes the raw line is asynchronous to pclk and idles high.
`timescale 1ns/1ps
module sbc_line_filter #(
    parameter int FILT_CYC = sbc_pkg::FILT_CYC
) (
    // Clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // Line
    input  wire logic raw_in,
    input  wire logic filter_en,
    output logic      level_q
);
    import sbc_pkg::*;

    logic       meta_q;
    logic       sync_q;
    logic [5:0] stable_q;
    wire        settled = (stable_q >= 6'(FILT_CYC - 1));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_q <= 1'b1;
            sync_q <= 1'b1;
        end else begin
            meta_q <= raw_in;
            sync_q <= meta_q;
        end
    end

    // Filter trades response time for immunity to short glitches
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stable_q <= 6'h00;
            level_q  <= 1'b1;
        end else if (!filter_en || sync_q == level_q) begin
            stable_q <= 6'h00;
            level_q  <= sync_q;
        end else if (settled) begin
            stable_q <= 6'h00;
            level_q  <= sync_q;
        end else begin
            stable_q <= stable_q + 6'h01;
        end
    end

endmodule : sbc_line_filter

// >>> verilog/sbc_pkg.sv
// Constants, field layouts and carrier types of the two-wire status and clock-select block.
// Assumes an APB master with 32-bit data on pclk and a two-wire bus outside the chip.
// Behaviour
// - Ack flag set on low data at ninth rise
// - Ack clears: stop, next first clock, release, disable
// - Wait release in transmit ends wait, drops driver
// - Start condition sets start flag, address phase
// - Start clears: stop, first clock after address, release
// - Stop condition sets stop flag, bus free
// - Stop clears at address first clock, disable, reset
// - Read-only status byte, fixed layout, resets zero
// - Clock level flag follows line when enabled
// - Data level flag follows line when enabled
// - Speed bit written only by software, resets zero
// - Filter bit switches digital input filter on
// - Clock select: levels read-only, top bits zero
package sbc_pkg;

    // Register indices; byte address is four times the index
    localparam logic [15:0] IDX_STATUS   = 16'hFF79;
    localparam logic [15:0] IDX_CLKSEL   = 16'hFF7A;
    localparam logic [15:0] IDX_CONTROL  = 16'hFF70;
    localparam logic [15:0] IDX_IRQ_STAT = 16'hFF71;
    localparam logic [15:0] IDX_IRQ_MASK = 16'hFF72;

    // Reset values
    localparam logic [7:0] RST_STATUS  = 8'h00;
    localparam logic [7:0] RST_CLKSEL  = 8'h00;
    localparam logic [7:0] RST_CONTROL = 8'h00;
    localparam logic [2:0] RST_IRQ     = 3'h0;

    // Clock-select fields
    localparam int CLK_SCL_LVL  = 5;
    localparam int CLK_SDA_LVL  = 4;
    localparam int CLK_SPEED    = 3;
    localparam int CLK_FILTER   = 2;
    localparam int CLK_DIV_HI   = 1;
    localparam int CLK_DIV_LO   = 0;
    localparam logic [7:0] CLK_WR_MASK = 8'h0F;

    // Control fields
    localparam int CTL_ENABLE   = 7;
    localparam int CTL_RELEASE  = 6;
    localparam int CTL_WAIT_REL = 5;
    localparam int CTL_TX_SET   = 3;
    localparam int CTL_TX_LEVEL = 0;

    // Interrupt fields
    localparam int IRQ_STOP  = 0;
    localparam int IRQ_START = 1;
    localparam int IRQ_ACK   = 2;

    // Bit counts within a byte
    localparam logic [3:0] BIT_NINTH = 4'h8;
    localparam logic [3:0] BIT_DONE  = 4'h9;

    // Timing
    localparam int CLK_PERIOD_NS = 8;
    localparam int FILT_DELAY_NS = 250;
    localparam int FILT_CYC =
        (FILT_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef struct packed {
        logic master_status;
        logic arbitration_lost;
        logic extension_code_seen;
        logic address_match;
        logic transmit_status;
        logic ack_detected;
        logic start_detected;
        logic stop_detected;
    } sbc_status_s;

    typedef struct packed {
        logic scl;
        logic sda;
    } sbc_lines_s;

    function automatic logic [31:0] sbc_addr(input logic [15:0] idx);
        sbc_addr = {14'h0000, idx, 2'b00};
    endfunction : sbc_addr

endpackage : sbc_pkg

// >>> verilog/sbc_status_clksel.sv
// Status flags, clock select, wait control and APB register file of the two-wire block.
// Assumes an APB master on pclk and open-drain clock and data lines on the pins.
`timescale 1ns/1ps
module sbc_status_clksel #(
    parameter int FILT_CYC = sbc_pkg::FILT_CYC
) (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Serial clock line
    input  wire logic        serial_clock_line_in,
    output logic             serial_clock_line_out,
    output logic             serial_clock_line_oe_n,
    // Serial data line
    input  wire logic        serial_data_line_in,
    output logic             serial_data_line_out,
    output logic             serial_data_line_oe_n,
    // Interrupt
    output logic             irq
);
    import sbc_pkg::*;

    // Registers
    sbc_status_s stat_q;
    sbc_lines_s  lvl_q;
    sbc_lines_s  prev_q;
    sbc_lines_s  filt;
    logic [3:0]  clksel_q;
    logic        enable_q;
    logic        tx_level_q;
    logic        in_xfer_q;
    logic        addr_phase_q;
    logic        wait_q;
    logic [3:0]  bit_cnt_q;
    logic [2:0]  irq_stat_q;
    logic [2:0]  irq_mask_q;
    logic [31:0] prdata_q;
    logic        pready_q;
    logic        pslverr_q;
    logic        irq_q;
    logic        scl_oe_n_q;
    logic        sda_oe_n_q;

    // Line synchronisers and filters
    wire [1:0] raw_lines = {serial_clock_line_in, serial_data_line_in};
    wire [1:0] filt_lines;

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_line
            sbc_line_filter #(
                .FILT_CYC  (FILT_CYC)
            ) u_filt (
                .pclk      (pclk),
                .presetn   (presetn),
                .raw_in    (raw_lines[g]),
                .filter_en (clksel_q[CLK_FILTER]),
                .level_q   (filt_lines[g])
            );
        end
    endgenerate

    assign filt.scl = filt_lines[1];
    assign filt.sda = filt_lines[0];

    // Bus condition decode
    wire scl_rise   = filt.scl & ~prev_q.scl;
    wire scl_fall   = ~filt.scl & prev_q.scl;
    wire start_cond = enable_q & prev_q.scl & filt.scl & prev_q.sda & ~filt.sda;
    wire stop_cond  = enable_q & prev_q.scl & filt.scl & ~prev_q.sda & filt.sda;
    wire first_rise = enable_q & in_xfer_q & scl_rise & (bit_cnt_q == 4'h0);
    wire ninth_rise = enable_q & in_xfer_q & scl_rise & (bit_cnt_q == BIT_NINTH);
    wire ninth_fall = enable_q & in_xfer_q & scl_fall & (bit_cnt_q == BIT_DONE);

    // APB decode
    wire acc        = psel & penable & pready_q;
    wire wr         = acc & pwrite;
    wire hit_stat   = (paddr == sbc_addr(IDX_STATUS));
    wire hit_clk    = (paddr == sbc_addr(IDX_CLKSEL));
    wire hit_ctl    = (paddr == sbc_addr(IDX_CONTROL));
    wire hit_istat  = (paddr == sbc_addr(IDX_IRQ_STAT));
    wire hit_imask  = (paddr == sbc_addr(IDX_IRQ_MASK));
    wire hit_any    = hit_stat | hit_clk | hit_ctl | hit_istat | hit_imask;
    wire wr_clk     = wr & hit_clk;
    wire wr_ctl     = wr & hit_ctl;
    wire wr_istat   = wr & hit_istat;
    wire wr_imask   = wr & hit_imask;
    wire enable_d   = wr_ctl ? pwdata[CTL_ENABLE] : enable_q;
    wire release_p  = wr_ctl & pwdata[CTL_RELEASE];
    wire wait_rel_p = wr_ctl & pwdata[CTL_WAIT_REL];
    wire tx_set_p   = wr_ctl & pwdata[CTL_TX_SET];
    wire disable_p  = enable_q & ~enable_d;

    // Interrupt events
    wire [2:0] irq_evt = {ninth_rise & ~filt.sda, start_cond, stop_cond};

    // Read data selection
    wire [7:0] clk_rd  = {2'b00, lvl_q.scl, lvl_q.sda, clksel_q};
    wire [7:0] ctl_rd  = {enable_q, 6'h00, tx_level_q};
    wire [7:0] rd_byte =
        hit_stat  ? stat_q :
        hit_clk   ? clk_rd :
        hit_ctl   ? ctl_rd :
        hit_istat ? {5'h00, irq_stat_q} :
        hit_imask ? {5'h00, irq_mask_q} : 8'h00;

    // APB handshake: one wait cycle, then the answer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            prdata_q  <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end else begin
            pready_q  <= psel & penable & ~pready_q;
            prdata_q  <= {24'h00_0000, rd_byte};
            pslverr_q <= psel & penable & ~pready_q & ~hit_any;
        end
    end

    // Control register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            enable_q   <= RST_CONTROL[CTL_ENABLE];
            tx_level_q <= RST_CONTROL[CTL_TX_LEVEL];
        end else if (wr_ctl) begin
            enable_q   <= pwdata[CTL_ENABLE];
            tx_level_q <= pwdata[CTL_TX_LEVEL];
        end
    end

    // Clock select: only the low nibble is writable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clksel_q <= RST_CLKSEL[3:0];
        end else if (wr_clk) begin
            clksel_q <= pwdata[3:0] & CLK_WR_MASK[3:0];
        end
    end

    // Line level flags read zero while disabled
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lvl_q  <= '0;
            prev_q <= '{scl: 1'b1, sda: 1'b1};
        end else begin
            lvl_q.scl <= enable_q & filt.scl;
            lvl_q.sda <= enable_q & filt.sda;
            prev_q    <= filt;
        end
    end

    // Byte framing
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            in_xfer_q    <= 1'b0;
            addr_phase_q <= 1'b0;
            bit_cnt_q    <= 4'h0;
        end else if (!enable_q || stop_cond) begin
            in_xfer_q    <= 1'b0;
            addr_phase_q <= 1'b0;
            bit_cnt_q    <= 4'h0;
        end else if (start_cond) begin
            in_xfer_q    <= 1'b1;
            addr_phase_q <= 1'b1;
            bit_cnt_q    <= 4'h0;
        end else if (ninth_fall) begin
            addr_phase_q <= 1'b0;
            bit_cnt_q    <= 4'h0;
        end else if (in_xfer_q && scl_rise) begin
            bit_cnt_q    <= bit_cnt_q + 4'h1;
        end
    end

    // Acknowledge flag
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stat_q.ack_detected <= RST_STATUS[2];
        end else if (!enable_q || disable_p) begin
            stat_q.ack_detected <= 1'b0;
        end else if (ninth_rise && !filt.sda) begin
            // A sampled acknowledge wins over a release in the same cycle
            stat_q.ack_detected <= 1'b1;
        end else if (stop_cond || release_p || first_rise) begin
            stat_q.ack_detected <= 1'b0;
        end
    end

    // Start flag
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stat_q.start_detected <= RST_STATUS[1];
        end else if (!enable_q) begin
            stat_q.start_detected <= 1'b0;
        end else if (start_cond) begin
            // A seen start wins over a release in the same cycle
            stat_q.start_detected <= 1'b1;
        end else if (stop_cond || release_p) begin
            stat_q.start_detected <= 1'b0;
        end else if (first_rise && !addr_phase_q) begin
            stat_q.start_detected <= 1'b0;
        end
    end

    // Stop flag survives a bus release command
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stat_q.stop_detected <= RST_STATUS[0];
        end else if (!enable_q) begin
            stat_q.stop_detected <= 1'b0;
        end else if (stop_cond) begin
            stat_q.stop_detected <= 1'b1;
        end else if (first_rise && addr_phase_q) begin
            stat_q.stop_detected <= 1'b0;
        end
    end

    // Transmit status and wait state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stat_q.transmit_status <= RST_STATUS[3];
            wait_q                 <= 1'b0;
        end else if (!enable_q || release_p) begin
            stat_q.transmit_status <= 1'b0;
            wait_q                 <= 1'b0;
        end else if (wait_rel_p && wait_q) begin
            wait_q                 <= 1'b0;
            stat_q.transmit_status <= 1'b0;
        end else begin
            if (tx_set_p) begin
                stat_q.transmit_status <= 1'b1;
            end
            if (ninth_fall) begin
                wait_q <= 1'b1;
            end
        end
    end

    // Flags outside this block stay at their reset value
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stat_q.master_status       <= RST_STATUS[7];
            stat_q.arbitration_lost    <= RST_STATUS[6];
            stat_q.extension_code_seen <= RST_STATUS[5];
            stat_q.address_match       <= RST_STATUS[4];
        end else begin
            stat_q.master_status       <= 1'b0;
            stat_q.arbitration_lost    <= 1'b0;
            stat_q.extension_code_seen <= 1'b0;
            stat_q.address_match       <= 1'b0;
        end
    end

    // Line drivers: low output enable means the pin is pulled low
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            scl_oe_n_q <= 1'b1;
            sda_oe_n_q <= 1'b1;
        end else begin
            scl_oe_n_q <= ~(enable_q & wait_q);
            sda_oe_n_q <= ~(enable_q & stat_q.transmit_status & ~tx_level_q);
        end
    end

    // Interrupt status: a new event wins over a write-one clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat_q <= RST_IRQ;
            irq_mask_q <= RST_IRQ;
            irq_q      <= 1'b0;
        end else begin
            irq_stat_q <= (irq_stat_q & ~(wr_istat ? pwdata[2:0] : 3'h0)) | irq_evt;
            if (wr_imask) begin
                irq_mask_q <= pwdata[2:0];
            end
            irq_q <= |(irq_stat_q & irq_mask_q);
        end
    end

    // Outputs
    assign prdata                 = prdata_q;
    assign pready                 = pready_q;
    assign pslverr                = pslverr_q;
    assign serial_clock_line_out  = 1'b0;
    assign serial_data_line_out   = 1'b0;
    assign serial_clock_line_oe_n = scl_oe_n_q;
    assign serial_data_line_oe_n  = sda_oe_n_q;
    assign irq                    = irq_q;

endmodule : sbc_status_clksel
